// File: rtl/word_serial_slave.sv
// Purpose: Backplane word-serial slave of a 48-line digital I/O module.
// Assumes: Inputs synchronous to clock; bus master holds strobe until ack, then drops it.
// Notes: Command parsing and the I/O datapath sit outside and use the cmd and resp ports.
`default_nettype none
module word_serial_slave #(
	parameter int SELFTEST_CYCLES = slave_pkg::SELFTEST_CYC,
	parameter logic [15:0] MODEL_NUMBER = 16'h0123,
	parameter logic [11:0] MAKER_ID = 12'h5a5
) (
	input wire logic clock,
	input wire logic rst,
	input wire slave_pkg::bus_req_s bus,
	input wire logic iack_strobe,
	input wire logic [2:0] iack_level,
	input wire logic [7:0] la_sw,
	input wire logic [2:0] irq_level_sw,
	input wire logic halt_sw,
	input wire logic sys_reset,
	input wire logic request_true,
	input wire logic resp_valid,
	input wire logic [7:0] resp_byte,
	input wire logic [15:0] status_word,
	output logic bus_ack,
	output logic [15:0] bus_rdata,
	output logic [7:1] irq_req,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	output logic cmd_end,
	output logic cmd_clear,
	output logic byte_wanted,
	output logic power_led,
	output logic message_activity_indicator
);
	// MAKER_ID and MODEL_NUMBER defaults are arbitrary values.
	localparam logic [15:0] DEVTYPE = ~MODEL_NUMBER & ~(16'h0001 << slave_pkg::DEVTYPE_CLR_BIT);
	localparam logic [12:0] WR_GAP = 13'(slave_pkg::WR_GAP_CYC);
	localparam logic [12:0] RD_GAP = 13'(slave_pkg::RD_GAP_CYC);
	localparam logic [27:0] TEST_CNT = 28'(SELFTEST_CYCLES);

	function automatic logic reg_hit(input logic [15:0] a, input logic [7:0] la,
			input logic [5:0] off);
		reg_hit = (a == (slave_pkg::CFG_BASE | {2'h0, la, off}));
	endfunction

	function automatic logic no_effect(input logic [7:0] c);
		no_effect = (c == slave_pkg::CMD_GRANT_DEVICE) || (c == slave_pkg::CMD_TRIGGER) ||
			(c == slave_pkg::CMD_SET_LOCK) || (c == slave_pkg::CMD_CLEAR_LOCK) ||
			(c == slave_pkg::CMD_IDENT_CMDR);
	endfunction

	slave_pkg::phase_e phase_reg, phase_next;
	logic [27:0] test_cnt_reg, test_cnt_next;
	logic [12:0] wr_cnt_reg, wr_cnt_next, rd_cnt_reg, rd_cnt_next;
	logic [15:0] resp_reg, resp_next;
	logic rd_rdy_reg, rd_rdy_next, normal_reg, normal_next;
	logic unrec_reg, unrec_next, reqt_reg, reqt_next;
	logic ack_next, valid_next, end_next, clear_next, want_next, msg_next;
	logic [15:0] rdata_next;
	logic [7:0] cbyte_next;
	logic [7:1] irq_next;
	// Marks a fresh unknown command, so an acknowledge in the same cycle cannot lose it.
	logic unrec_set;
	logic access, wr_cmd, rd_resp, iack_hit, soft_reset, ready;
	logic [7:0] op;
	logic [15:0] statctl;

	assign ready = (phase_reg == slave_pkg::ST_RUN);
	assign access = bus.strobe && !bus_ack;
	assign op = bus.wdata[15:8];
	assign wr_cmd = access && bus.write && reg_hit(bus.addr, la_sw, slave_pkg::OFF_DATALOW);
	assign rd_resp = access && !bus.write && reg_hit(bus.addr, la_sw, slave_pkg::OFF_DATALOW);
	assign iack_hit = iack_strobe && !bus_ack && (iack_level == irq_level_sw) &&
		(irq_level_sw != 3'h0) && (unrec_reg || reqt_reg);
	// Backplane system reset always restarts; a manager reset only with halt on.
	assign soft_reset = sys_reset || (access && bus.write && halt_sw &&
		reg_hit(bus.addr, la_sw, slave_pkg::OFF_STATCTL) &&
		bus.wdata[slave_pkg::CTL_RESET_BIT]);
	assign statctl = 16'((ready ? 16'h0001 : 16'h0000) << slave_pkg::STAT_READY_BIT) |
		16'((ready ? 16'h0001 : 16'h0000) << slave_pkg::STAT_PASSED_BIT) |
		16'((normal_reg ? 16'h0001 : 16'h0000) << slave_pkg::STAT_NORMAL_BIT);

	always_comb begin
		phase_next = phase_reg;
		test_cnt_next = test_cnt_reg;
		wr_cnt_next = (wr_cnt_reg != 13'h0) ? wr_cnt_reg - 13'h1 : 13'h0;
		rd_cnt_next = (rd_cnt_reg != 13'h0) ? rd_cnt_reg - 13'h1 : 13'h0;
		resp_next = resp_reg;
		rd_rdy_next = rd_rdy_reg;
		normal_next = normal_reg;
		unrec_next = unrec_reg;
		unrec_set = 1'b0;
		reqt_next = reqt_reg || request_true;
		want_next = byte_wanted;
		msg_next = ready ? 1'b0 : (message_activity_indicator ^ access);
		ack_next = 1'b0;
		rdata_next = bus_rdata;
		valid_next = 1'b0;
		cbyte_next = cmd_byte;
		end_next = 1'b0;
		clear_next = 1'b0;
		case (phase_reg)
			slave_pkg::ST_TEST: begin
				if (test_cnt_reg == 28'h1) begin
					phase_next = slave_pkg::ST_RUN;
				end
				test_cnt_next = test_cnt_reg - 28'h1;
			end
			slave_pkg::ST_RUN: begin
			end
			default: begin
				phase_next = slave_pkg::ST_TEST;
			end
		endcase
		// Only the configuration window and acknowledge cycles at our level are answered.
		if (bus.strobe && (bus.addr[15:6] == {slave_pkg::CFG_BASE[15:14], la_sw})) begin
			ack_next = 1'b1;
		end
		if (access) begin
			case (bus.addr[5:0])
				slave_pkg::OFF_ID: rdata_next = {slave_pkg::ID_CLASS_MSG,
					slave_pkg::ID_SPACE_A16, MAKER_ID};
				slave_pkg::OFF_DEVTYPE: rdata_next = DEVTYPE;
				slave_pkg::OFF_STATCTL: rdata_next = statctl;
				slave_pkg::OFF_PROTOCOL: rdata_next = slave_pkg::PROTOCOL_WORD;
				slave_pkg::OFF_RESPONSE: rdata_next = 16'(
					((wr_cnt_reg == 13'h0) ? 16'h0001 : 16'h0000) << slave_pkg::RESP_WR_RDY_BIT) |
					16'(((rd_rdy_reg && rd_cnt_reg == 13'h0) ? 16'h0001 : 16'h0000) <<
					slave_pkg::RESP_RD_RDY_BIT);
				slave_pkg::OFF_DATALOW: rdata_next = resp_reg;
				default: rdata_next = 16'h0000;
			endcase
		end
		if (rd_resp) begin
			rd_rdy_next = 1'b0;
			rd_cnt_next = RD_GAP;
		end
		if (byte_wanted && resp_valid) begin
			resp_next = {8'h00, resp_byte};
			rd_rdy_next = 1'b1;
			want_next = 1'b0;
		end
		if (wr_cmd) begin
			wr_cnt_next = WR_GAP;
			case (op)
				slave_pkg::CMD_BYTE_AVAIL, slave_pkg::CMD_BYTE_AVAIL_END: begin
					valid_next = ready;
					cbyte_next = bus.wdata[7:0];
					end_next = ready && (op == slave_pkg::CMD_BYTE_AVAIL_END);
				end
				slave_pkg::CMD_BYTE_REQ: want_next = 1'b1;
				slave_pkg::CMD_BEGIN_NORMAL: normal_next = 1'b1;
				slave_pkg::CMD_READ_PROTOCOL: begin
					resp_next = slave_pkg::PROTOCOL_WORD;
					rd_rdy_next = 1'b1;
				end
				slave_pkg::CMD_READ_STATUS: begin
					resp_next = status_word;
					rd_rdy_next = 1'b1;
				end
				slave_pkg::CMD_CLEAR: begin
					// Clears the interface only; module operations carry on.
					clear_next = 1'b1;
					want_next = 1'b0;
					rd_rdy_next = 1'b0;
				end
				default: begin
					if (!no_effect(op)) begin
						unrec_next = 1'b1;
						unrec_set = 1'b1;
					end
				end
			endcase
		end
		if (iack_hit) begin
			ack_next = 1'b1;
			rdata_next = {unrec_reg ? slave_pkg::EV_UNRECOGNIZED : slave_pkg::EV_REQUEST_TRUE,
				la_sw};
			// A new event in the acknowledge cycle stays pending.
			if (unrec_reg) begin
				unrec_next = unrec_set;
			end else begin
				reqt_next = request_true;
			end
		end
		irq_next = 7'h00;
		if (irq_level_sw != 3'h0 && (unrec_next || reqt_next)) begin
			// Level n lights bit n of irq_req; level 0 keeps all requests off.
			irq_next = 7'(8'h01 << (irq_level_sw - 3'h1));
		end
		if (soft_reset) begin
			phase_next = slave_pkg::ST_TEST;
			test_cnt_next = TEST_CNT;
			normal_next = 1'b0;
			unrec_next = 1'b0;
			reqt_next = 1'b0;
			want_next = 1'b0;
			rd_rdy_next = 1'b0;
			irq_next = 7'h00;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_reg <= slave_pkg::ST_TEST;
			test_cnt_reg <= TEST_CNT;
			wr_cnt_reg <= 13'h0;
			rd_cnt_reg <= 13'h0;
			resp_reg <= 16'h0000;
			rd_rdy_reg <= 1'b0;
			normal_reg <= 1'b0;
			unrec_reg <= 1'b0;
			reqt_reg <= 1'b0;
			bus_ack <= 1'b0;
			bus_rdata <= 16'h0000;
			irq_req <= 7'h00;
			cmd_valid <= 1'b0;
			cmd_byte <= 8'h00;
			cmd_end <= 1'b0;
			cmd_clear <= 1'b0;
			byte_wanted <= 1'b0;
			power_led <= 1'b0;
			message_activity_indicator <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			test_cnt_reg <= test_cnt_next;
			wr_cnt_reg <= wr_cnt_next;
			rd_cnt_reg <= rd_cnt_next;
			resp_reg <= resp_next;
			rd_rdy_reg <= rd_rdy_next;
			normal_reg <= normal_next;
			unrec_reg <= unrec_next;
			reqt_reg <= reqt_next;
			bus_ack <= ack_next;
			bus_rdata <= rdata_next;
			irq_req <= irq_next;
			cmd_valid <= valid_next;
			cmd_byte <= cbyte_next;
			cmd_end <= end_next;
			cmd_clear <= clear_next;
			byte_wanted <= want_next;
			power_led <= (phase_next == slave_pkg::ST_RUN);
			message_activity_indicator <= msg_next;
		end
	end

	sequence cmd_taken;
		wr_cmd && !soft_reset;
	endsequence

	sequence acked;
		##1 bus_ack;
	endsequence

	AST_CMD_ACKED: assert property (@(posedge clock) disable iff (rst)
		cmd_taken |-> acked) else $error("command write not acknowledged");
	AST_IACK_ADDR: assert property (@(posedge clock) disable iff (rst)
		iack_hit && !soft_reset |=> bus_ack && bus_rdata[7:0] == $past(la_sw))
		else $error("acknowledge does not carry logical address");
	AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (rst)
		irq_req != 7'h00 |-> (irq_req >> (irq_level_sw - 3'h1)) == 7'h01 || $changed(irq_level_sw))
		else $error("interrupt on wrong level");
	AST_UNREC: assert property (@(posedge clock) disable iff (rst)
		(cmd_taken and (op == 8'h00)) |=> unrec_reg) else $error("unknown command raised no event");
	AST_NOEFFECT: assert property (@(posedge clock) disable iff (rst)
		(cmd_taken and (no_effect(op) && !unrec_reg && !iack_hit)) |=> !unrec_reg && !cmd_valid)
		else $error("no-effect command changed state");
	AST_DEVTYPE: assert property (@(posedge clock) disable iff (rst)
		access && !bus.write && bus.addr[5:0] == slave_pkg::OFF_DEVTYPE |=>
		!bus_rdata[slave_pkg::DEVTYPE_CLR_BIT] && bus_rdata == DEVTYPE)
		else $error("device type code wrong");
	AST_WR_GAP: assert property (@(posedge clock) disable iff (rst)
		cmd_taken |=> wr_cnt_reg == WR_GAP ##1 wr_cnt_reg == WR_GAP - 13'h1)
		else $error("write spacing counter not loaded");
	AST_HALT_BLOCK: assert property (@(posedge clock) disable iff (rst)
		ready && !halt_sw && !sys_reset |=> ready) else $error("reset taken with halt off");
	AST_GATE: assert property (@(posedge clock) disable iff (rst)
		!ready |=> !cmd_valid) else $error("command byte passed during self test");
	AST_LED: assert property (@(posedge clock) disable iff (rst)
		ready && !soft_reset |=> power_led && !message_activity_indicator)
		else $error("lamps wrong after power-up");

	sequence clear_taken;
		wr_cmd && !soft_reset && op == slave_pkg::CMD_CLEAR;
	endsequence

	AST_BYTE_REQ: assert property (@(posedge clock) disable iff (rst)
		(cmd_taken and (op == slave_pkg::CMD_BYTE_REQ)) |=> byte_wanted)
		else $error("byte request left no pending request");
	AST_CLEAR: assert property (@(posedge clock) disable iff (rst)
		clear_taken |=> cmd_clear && !byte_wanted && !rd_rdy_reg)
		else $error("clear did not reset the interface");
	AST_BYTE_PASS: assert property (@(posedge clock) disable iff (rst)
		(cmd_taken and (ready && op == slave_pkg::CMD_BYTE_AVAIL_END)) |=>
		cmd_valid && cmd_end && cmd_byte == $past(bus.wdata[7:0]))
		else $error("byte available not passed on");
	AST_RT_EVENT: assert property (@(posedge clock) disable iff (rst)
		request_true && !soft_reset && irq_level_sw != 3'h0 |=> irq_req != 7'h00)
		else $error("request true raised no interrupt");
	AST_SYSRST: assert property (@(posedge clock) disable iff (rst)
		sys_reset |=> !ready && !power_led && irq_req == 7'h00)
		else $error("system reset did not restart the module");
	AST_RESP_TAKEN: assert property (@(posedge clock) disable iff (rst)
		byte_wanted && resp_valid && !soft_reset && !wr_cmd |=>
		!byte_wanted && rd_rdy_reg && resp_reg == {8'h00, $past(resp_byte)})
		else $error("response byte not taken");
endmodule
`default_nettype wire

// File: rtl/slave_pkg.sv
// Purpose: Shared constants and carriers for the message-based word-serial bus slave.
// Assumes: 50 MHz clock; A16 address space, D16 data.
// Notes: Command codes, register offsets and field positions are fixed here.
`default_nettype none
package slave_pkg;
	typedef struct packed {
		logic strobe;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bus_req_s;
	localparam int CLK_HZ = 50_000_000;
	localparam int SELFTEST_S = 5;
	localparam int WR_MAX_BPS = 20_000;
	localparam int RD_MAX_BPS = 400_000;
	localparam int WR_GAP_CYC = (CLK_HZ + WR_MAX_BPS - 1) / WR_MAX_BPS;
	localparam int RD_GAP_CYC = (CLK_HZ + RD_MAX_BPS - 1) / RD_MAX_BPS;
	localparam int SELFTEST_CYC = SELFTEST_S * CLK_HZ;
	localparam logic [15:0] CFG_BASE = 16'hc000;
	localparam logic [5:0] OFF_ID = 6'h00;
	localparam logic [5:0] OFF_DEVTYPE = 6'h02;
	localparam logic [5:0] OFF_STATCTL = 6'h04;
	localparam logic [5:0] OFF_PROTOCOL = 6'h08;
	localparam logic [5:0] OFF_RESPONSE = 6'h0a;
	localparam logic [5:0] OFF_DATALOW = 6'h0e;
	localparam int CTL_RESET_BIT = 0;
	localparam int STAT_PASSED_BIT = 2;
	localparam int STAT_READY_BIT = 3;
	localparam int STAT_NORMAL_BIT = 4;
	localparam int RESP_WR_RDY_BIT = 9;
	localparam int RESP_RD_RDY_BIT = 10;
	localparam int DEVTYPE_CLR_BIT = 11;
	localparam logic [1:0] ID_CLASS_MSG = 2'h2;
	localparam logic [1:0] ID_SPACE_A16 = 2'h3;
	localparam logic [15:0] PROTOCOL_WORD = 16'hfff7;
	localparam logic [7:0] CMD_BYTE_AVAIL = 8'hbc;
	localparam logic [7:0] CMD_BYTE_AVAIL_END = 8'hbd;
	localparam logic [7:0] CMD_BYTE_REQ = 8'hde;
	localparam logic [7:0] CMD_BEGIN_NORMAL = 8'hfc;
	localparam logic [7:0] CMD_READ_PROTOCOL = 8'he7;
	localparam logic [7:0] CMD_READ_STATUS = 8'hcf;
	localparam logic [7:0] CMD_CLEAR = 8'hff;
	localparam logic [7:0] CMD_GRANT_DEVICE = 8'hf0;
	localparam logic [7:0] CMD_TRIGGER = 8'hed;
	localparam logic [7:0] CMD_SET_LOCK = 8'ha5;
	localparam logic [7:0] CMD_CLEAR_LOCK = 8'ha4;
	localparam logic [7:0] CMD_IDENT_CMDR = 8'hbe;
	localparam logic [7:0] EV_UNRECOGNIZED = 8'hfd;
	localparam logic [7:0] EV_REQUEST_TRUE = 8'hfe;
	typedef enum logic [1:0] {
		ST_TEST = 2'b01,
		ST_RUN = 2'b10
	} phase_e;
endpackage
`default_nettype wire

// File: verification/commander_model.sv
// Purpose: Backplane commander model issuing A16/D16 slave and acknowledge cycles.
// Assumes: Requests change just after a rising edge and stand until acknowledged or until the cycle gives up.
// Notes: Released lines carry inverted values so stale data never passes for live data.
`default_nettype none
module commander_model (
	input wire logic clock,
	input wire logic bus_ack,
	input wire logic [15:0] bus_rdata,
	output var slave_pkg::bus_req_s bus,
	output logic iack_strobe,
	output logic [2:0] iack_level
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus = '0;
		iack_strobe = 1'b0;
		iack_level = 3'h0;
	end
	// A cycle gives up after eight edges, which is how a refused access shows.
	task automatic cycle(input logic ia, input logic wr, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		q = 16'h0;
		@(posedge clock);
		if (ia) begin
			iack_level <= a[2:0];
			iack_strobe <= 1'b1;
		end else begin
			bus <= '{1'b1, wr, a, d};
		end
		while (!ok && n < 8) begin
			@(posedge clock);
			n++;
			if (bus_ack === 1'b1) begin
				ok = 1'b1;
				q = bus_rdata;
			end
		end
		iack_strobe <= 1'b0;
		iack_level <= ~a[2:0];
		if (!ia) begin
			bus <= '{1'b0, ~wr, ~a, ~d};
		end
		repeat (2) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// File: verification/message_based_bus_slave_interface_bench.sv
// Purpose: Self-checking bench for the word-serial bus slave.
// Assumes: Self test shortened to TEST_CYC cycles; the commander model runs all cycles.
// Notes: Command pulses last one cycle, so a monitor tallies them for later checks.
`default_nettype none
module message_based_bus_slave_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TEST_CYC = 20;
	localparam logic [15:0] MODEL = 16'h0123;
	localparam logic [11:0] MAKER = 12'h3c3; // Arbitrary maker code.
	localparam logic [7:0] QUIET [5] = '{slave_pkg::CMD_GRANT_DEVICE, slave_pkg::CMD_TRIGGER,
		slave_pkg::CMD_SET_LOCK, slave_pkg::CMD_CLEAR_LOCK, slave_pkg::CMD_IDENT_CMDR};
	logic clock, rst, iack_strobe, halt_sw, sys_reset, request_true, resp_valid, bus_ack;
	logic cmd_valid, cmd_end, cmd_clear, byte_wanted, power_led, msg_lamp, last_end, ok;
	logic [2:0] iack_level, irq_level_sw;
	logic [7:0] la_sw, resp_byte, cmd_byte, last_byte;
	logic [15:0] status_word, bus_rdata, q, dt;
	logic [7:1] irq_req, hot;
	slave_pkg::bus_req_s bus;
	int n_fail, check_count, n_cmd, n_clr, cycles;
	word_serial_slave #(.SELFTEST_CYCLES(TEST_CYC), .MODEL_NUMBER(MODEL), .MAKER_ID(MAKER)) dut_u (
		.clock(clock), .rst(rst), .bus(bus), .iack_strobe(iack_strobe),
		.iack_level(iack_level), .la_sw(la_sw), .irq_level_sw(irq_level_sw),
		.halt_sw(halt_sw), .sys_reset(sys_reset), .request_true(request_true),
		.resp_valid(resp_valid), .resp_byte(resp_byte), .status_word(status_word),
		.bus_ack(bus_ack), .bus_rdata(bus_rdata), .irq_req(irq_req), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .cmd_end(cmd_end), .cmd_clear(cmd_clear),
		.byte_wanted(byte_wanted), .power_led(power_led), .message_activity_indicator(msg_lamp));
	commander_model cmdr_u (.clock(clock), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus(bus),
		.iack_strobe(iack_strobe), .iack_level(iack_level));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			last_byte = cmd_byte;
			last_end = cmd_end;
		end
		if (cmd_clear === 1'b1) begin
			n_clr++;
		end
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic wr, input logic [5:0] off, input logic [15:0] d);
		cmdr_u.cycle(1'b0, wr, {2'b11, la_sw, off}, d, q, ok);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] b);
		acc(1'b1, slave_pkg::OFF_DATALOW, {op, b});
	endtask
	task automatic iack(input logic [2:0] lv);
		cmdr_u.cycle(1'b1, 1'b0, {13'h0, lv}, 16'h0, q, ok);
	endtask
	task automatic t_selftest();
		acc(1'b0, slave_pkg::OFF_ID, 16'h0);
		check("lamp", {14'h0, power_led, msg_lamp}, 16'h1);
		cmd(slave_pkg::CMD_BYTE_AVAIL, 8'h41);
		check("early", {ok, n_cmd[14:0]}, 16'h8000);
		repeat (TEST_CYC) @(posedge clock);
		check("power", {14'h0, power_led, msg_lamp}, 16'h2);
	endtask
	task automatic t_regs();
		acc(1'b0, slave_pkg::OFF_ID, 16'h0);
		check("id", q, {slave_pkg::ID_CLASS_MSG, slave_pkg::ID_SPACE_A16, MAKER});
		dt = ~MODEL;
		dt[11] = 1'b0;
		acc(1'b1, slave_pkg::OFF_DEVTYPE, 16'h1234);
		acc(1'b0, slave_pkg::OFF_DEVTYPE, 16'h0);
		check("devtype", q, dt);
		acc(1'b0, slave_pkg::OFF_PROTOCOL, 16'h0);
		check("protocol", q, slave_pkg::PROTOCOL_WORD);
		cmdr_u.cycle(1'b0, 1'b0, {2'b11, ~la_sw, 6'h00}, 16'h0, q, ok);
		check("foreign", {15'h0, ok}, 16'h0);
	endtask
	task automatic t_cmds();
		for (int i = 0; i < 2; i++) begin
			cmd(i ? slave_pkg::CMD_BYTE_AVAIL_END : slave_pkg::CMD_BYTE_AVAIL, 8'h30 + 8'(i));
			check("byte", {n_cmd[6:0], last_end, last_byte}, {7'(i + 1), 1'(i), 8'h30 + 8'(i)});
		end
		foreach (QUIET[k]) begin
			cmd(QUIET[k], 8'h00);
			check("quiet", {ok, byte_wanted, irq_req, n_clr[6:0]}, 16'h8000);
		end
		cmd(slave_pkg::CMD_CLEAR, 8'h00);
		check("clear", n_clr[15:0], 16'h1);
		cmd(slave_pkg::CMD_BYTE_REQ, 8'h00);
		check("wanted", {15'h0, byte_wanted}, 16'h1);
		resp_byte <= 8'h4b;
		resp_valid <= 1'b1;
		@(posedge clock);
		resp_valid <= 1'b0;
		repeat (2) @(posedge clock);
		acc(1'b0, slave_pkg::OFF_RESPONSE, 16'h0);
		check("rd rdy", {14'h0, q[slave_pkg::RESP_RD_RDY_BIT], byte_wanted}, 16'h2);
		check("wr rdy", {15'h0, q[slave_pkg::RESP_WR_RDY_BIT]}, 16'h0);
		acc(1'b0, slave_pkg::OFF_DATALOW, 16'h0);
		check("resp", q, 16'h004b);
		status_word <= 16'h1e2d;
		cmd(slave_pkg::CMD_READ_STATUS, 8'h00);
		acc(1'b0, slave_pkg::OFF_DATALOW, 16'h0);
		check("status", q, 16'h1e2d);
		cmd(slave_pkg::CMD_READ_PROTOCOL, 8'h00);
		acc(1'b0, slave_pkg::OFF_DATALOW, 16'h0);
		check("rd proto", q, slave_pkg::PROTOCOL_WORD);
		cmd(slave_pkg::CMD_BEGIN_NORMAL, 8'h00);
		acc(1'b0, slave_pkg::OFF_STATCTL, 16'h0);
		check("normal", q, 16'h001c);
	endtask
	task automatic t_events();
		for (int l = 1; l < 8; l++) begin
			irq_level_sw <= 3'(l);
			cmd(8'h00, 8'(l));
			hot = '0;
			hot[l] = 1'b1;
			check("irq", {ok, 8'h0, irq_req}, {1'b1, 8'h0, hot});
			iack(3'(l % 7 + 1));
			check("wrong lvl", {15'h0, ok}, 16'h0);
			iack(3'(l));
			check("iack", q, {slave_pkg::EV_UNRECOGNIZED, la_sw});
			check("irq clr", {9'h0, irq_req}, 16'h0);
		end
		request_true <= 1'b1;
		@(posedge clock);
		request_true <= 1'b0;
		repeat (2) @(posedge clock);
		check("rt irq", {9'h0, irq_req}, {9'h0, hot});
		iack(irq_level_sw);
		check("rt iack", q, {slave_pkg::EV_REQUEST_TRUE, la_sw});
	endtask
	task automatic t_resets();
		halt_sw <= 1'b0;
		acc(1'b1, slave_pkg::OFF_STATCTL, 16'h1);
		check("blocked", {15'h0, power_led}, 16'h1);
		sys_reset <= 1'b1;
		@(posedge clock);
		sys_reset <= 1'b0;
		repeat (2) @(posedge clock);
		check("sysrst", {15'h0, power_led}, 16'h0);
		repeat (TEST_CYC) @(posedge clock);
		halt_sw <= 1'b1;
		acc(1'b1, slave_pkg::OFF_STATCTL, 16'h1);
		check("halt on", {15'h0, power_led}, 16'h0);
		repeat (TEST_CYC + 2) @(posedge clock);
		check("ready", {15'h0, power_led}, 16'h1);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		halt_sw = 1'b1;
		sys_reset = 1'b0;
		request_true = 1'b0;
		resp_valid = 1'b0;
		resp_byte = 8'h00;
		status_word = 16'h0000;
		la_sw = 8'h2d;
		irq_level_sw = 3'h1;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		t_selftest();
		t_regs();
		t_cmds();
		t_events();
		t_resets();
		tally_and_finish();
	end
endmodule
`default_nettype wire
